// ==== core/asrc_host.sv ====
// Host controller driving a 512K x 8 asynchronous static RAM
//
// Summary of operation
// - Strobe stays high through every read
// - Never drive data while memory may drive
// - Read cycles spaced at least 40 ns
// - Reads last 55 ns for low supply
// - Write strobe low at least 30 ns
// - Chip selected 35 ns before write end
// - Deselect before retention, wait 5 ms after
`timescale 1ns/1ps
`include "asrc_regs.svh"

module asrc_host
  import asrc_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = `ASRC_RECOVERY_CYC
) (
  // Clock, reset, enable
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  // User request
  input  wire logic                     i_req_valid,
  input  wire asrc_req_t                i_req,
  output logic                          o_req_ready,
  output logic                          o_rdata_valid,
  output logic [`ASRC_DATA_W-1:0]       o_rdata,
  // Retention control
  input  wire logic                     i_retain,
  output logic                          o_retained,
  // Memory pins
  output logic [`ASRC_ADDR_W-1:0]       o_mem_addr,
  output asrc_ctl_t                     o_mem_ctl,
  input  wire logic [`ASRC_DATA_W-1:0]  i_mem_data,
  output logic [`ASRC_DATA_W-1:0]       o_mem_data,
  output logic                          o_mem_data_oe
);

  localparam int unsigned RD_CYC    = `ASRC_RD_CYC;
  localparam int unsigned WR_CYC    = `ASRC_WR_CYC;
  localparam int unsigned FLOAT_CYC = `ASRC_FLOAT_CYC;

  //////////////////////////////////////////////////////////////////////////
  asrc_state_t                  state_ff, nxt_state;
  logic [22:0]                  cnt_ff, nxt_cnt;
  logic [`ASRC_ADDR_W-1:0]      addr_ff, nxt_addr;
  logic [`ASRC_DATA_W-1:0]      wdata_ff, nxt_wdata;
  logic [`ASRC_DATA_W-1:0]      rdata_ff, nxt_rdata;
  logic                         rvalid_ff, nxt_rvalid;
  logic                         ready_ff, nxt_ready;
  logic                         retained_ff, nxt_retained;
  logic                         oe_ff, nxt_oe;
  asrc_ctl_t                    ctl_ff, nxt_ctl;

  localparam asrc_ctl_t CTL_DESEL = '{1'b1, 1'b0, 1'b1, 1'b1};
  localparam asrc_ctl_t CTL_READ  = '{1'b0, 1'b1, 1'b0, 1'b1};
  localparam asrc_ctl_t CTL_WRITE = '{1'b0, 1'b1, 1'b1, 1'b0};

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_addr     = addr_ff;
    nxt_wdata    = wdata_ff;
    nxt_rdata    = rdata_ff;
    nxt_rvalid   = 1'b0;
    nxt_ready    = 1'b0;
    nxt_retained = retained_ff;
    nxt_oe       = 1'b0;
    nxt_ctl      = CTL_DESEL;
    unique case (state_ff)
      ASRC_IDLE: begin
        nxt_ready = ~i_retain;
        if (i_retain) begin
          nxt_state = ASRC_RETAIN;
        end else if (i_req_valid && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_addr  = i_req.addr;
          nxt_wdata = i_req.wdata;
          if (i_req.write) begin
            // Select and strobe fall together, output enable high
            nxt_ctl   = CTL_WRITE;
            nxt_oe    = 1'b1;
            nxt_cnt   = 23'(WR_CYC);
            nxt_state = ASRC_WRITE;
          end else begin
            nxt_ctl   = CTL_READ;
            nxt_cnt   = 23'(RD_CYC);
            nxt_state = ASRC_READ;
          end
        end
      end
      ASRC_READ: begin
        nxt_ctl = CTL_READ;
        nxt_cnt = cnt_ff - 23'd1;
        if (cnt_ff == 23'd1) begin
          // Sample at full access time, then release the memory
          nxt_rdata  = i_mem_data;
          nxt_rvalid = 1'b1;
          nxt_ctl    = CTL_DESEL;
          nxt_cnt    = 23'(FLOAT_CYC);
          nxt_state  = ASRC_FLOAT;
        end
      end
      ASRC_WRITE: begin
        nxt_ctl = CTL_WRITE;
        nxt_oe  = 1'b1;
        nxt_cnt = cnt_ff - 23'd1;
        if (cnt_ff == 23'd1) begin
          // Strobe rises as both selects deassert; data still driven
          nxt_ctl   = CTL_DESEL;
          nxt_oe    = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = ASRC_IDLE;
        end
      end
      ASRC_FLOAT: begin
        // Memory may still drive: host stays off the bus
        nxt_cnt = cnt_ff - 23'd1;
        if (cnt_ff == 23'd1) begin
          nxt_ready = ~i_retain;
          nxt_state = ASRC_IDLE;
        end
      end
      ASRC_RETAIN: begin
        nxt_retained = 1'b1;
        if (!i_retain) begin
          nxt_retained = 1'b0;
          nxt_cnt      = 23'(RECOVERY_CYC);
          nxt_state    = ASRC_RECOVER;
        end
      end
      ASRC_RECOVER: begin
        nxt_cnt = cnt_ff - 23'd1;
        if (cnt_ff <= 23'd1) begin
          nxt_ready = ~i_retain;
          nxt_state = ASRC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff    <= ASRC_IDLE;
      cnt_ff      <= 23'h0;
      addr_ff     <= 19'h0;
      wdata_ff    <= 8'h0;
      rdata_ff    <= 8'h0;
      rvalid_ff   <= 1'b0;
      ready_ff    <= 1'b0;
      retained_ff <= 1'b0;
      oe_ff       <= 1'b0;
      ctl_ff      <= CTL_DESEL;
    end else if (i_ce) begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      addr_ff     <= nxt_addr;
      wdata_ff    <= nxt_wdata;
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= nxt_rvalid;
      ready_ff    <= nxt_ready;
      retained_ff <= nxt_retained;
      oe_ff       <= nxt_oe;
      ctl_ff      <= nxt_ctl;
    end
  end

  assign o_req_ready   = ready_ff;
  assign o_rdata_valid = rvalid_ff;
  assign o_rdata       = rdata_ff;
  assign o_retained    = retained_ff;
  assign o_mem_addr    = addr_ff;
  assign o_mem_ctl     = ctl_ff;
  assign o_mem_data    = wdata_ff;
  assign o_mem_data_oe = oe_ff;

  //////////////////////////////////////////////////////////////////////////
  // Strobe-low and selected time in cycles, for the width checks only
  logic [2:0]                   wr_low_ff, nxt_wr_low;
  logic [2:0]                   sel_on_ff, nxt_sel_on;

  always_comb begin
    nxt_wr_low = 3'h0;
    nxt_sel_on = 3'h0;
    // Saturate so a frozen strobe cannot wrap to a short count
    if (!ctl_ff.read_write_b) begin
      nxt_wr_low = wr_low_ff + {2'b00, (wr_low_ff != 3'h7)};
    end
    if (!ctl_ff.chip_select_low_active_b &&
        ctl_ff.chip_select_high_active) begin
      nxt_sel_on = sel_on_ff + {2'b00, (sel_on_ff != 3'h7)};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_low_ff <= 3'h0;
      sel_on_ff <= 3'h0;
    end else if (i_ce) begin
      wr_low_ff <= nxt_wr_low;
      sel_on_ff <= nxt_sel_on;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  AST_READ_STROBE_HIGH: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (state_ff == ASRC_READ) |-> o_mem_ctl.read_write_b)
    else $error("strobe low during read");

  AST_NO_DRIVE_ON_READ: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !o_mem_ctl.output_enable_b |-> !o_mem_data_oe)
    else $error("host drives while memory output enabled");

  AST_WRITE_OE_HIGH: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !o_mem_ctl.read_write_b |-> o_mem_ctl.output_enable_b && o_mem_data_oe)
    else $error("write without output enable high or data");

  AST_WRITE_PULSE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b || !i_ce)
    $rose(o_mem_ctl.read_write_b) |->
      int'(wr_low_ff) * `ASRC_CLK_PERIOD_NS >= `ASRC_WRITE_PULSE_MIN_NS)
    else $error("write strobe too short");

  AST_WRITE_SELECT: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b || !i_ce)
    $fell(o_mem_ctl.read_write_b) |->
      !o_mem_ctl.chip_select_low_active_b && o_mem_ctl.chip_select_high_active)
    else $error("select missing at write start");

  AST_WRITE_SELECT_TIME: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b || !i_ce)
    $rose(o_mem_ctl.read_write_b) |->
      int'(sel_on_ff) * `ASRC_CLK_PERIOD_NS >= `ASRC_SELECT_TO_WR_END_MIN_NS)
    else $error("select too short before write end");

  AST_WRITE_DATA_HOLD: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b || !i_ce)
    $rose(o_mem_ctl.read_write_b) |->
      o_mem_data_oe && $stable(o_mem_data))
    else $error("write data not held at write end");

  AST_READ_LEN: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b || !i_ce)
    $rose(state_ff == ASRC_READ) |-> (state_ff == ASRC_READ)[*2]
      ##1 o_rdata_valid)
    else $error("read cycle shorter than access time");

  AST_FLOAT_GAP: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b || !i_ce)
    $rose(o_rdata_valid) |-> !o_req_ready && !o_mem_data_oe)
    else $error("no float gap after read");

  AST_RETAIN_DESEL: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    o_retained |-> o_mem_ctl.chip_select_low_active_b && !o_req_ready)
    else $error("selected during retention");

endmodule

// ==== core/asrc_regs.svh ====
// Timing and geometry constants for the static RAM host controller
`ifndef ASRC_REGS_SVH
`define ASRC_REGS_SVH

`define ASRC_ADDR_W         19
`define ASRC_DATA_W         8
`define ASRC_CLK_PERIOD_NS  50
// Times in ns (higher supply, faster grade)
`define ASRC_READ_CYCLE_MIN_NS        40
`define ASRC_ADDRESS_TO_DATA_MAX_NS   40
`define ASRC_WRITE_PULSE_MIN_NS       30
`define ASRC_SELECT_TO_WR_END_MIN_NS  35
`define ASRC_DESELECT_TO_FLOAT_MAX_NS 20
`define ASRC_READ_DATA_HOLD_MIN_NS    10
// Lower supply, faster grade: read cycle and access time
`define ASRC_LOW_SUPPLY_READ_MIN_NS   55
// Retention recovery, in ms
`define ASRC_RECOVERY_MIN_MS          5
// Cycle counts: least times and the float maximum round up, ASRC_FLOOR rounds down, none below 1
`define ASRC_CEIL(ns) ((((ns) + `ASRC_CLK_PERIOD_NS - 1) / \
  `ASRC_CLK_PERIOD_NS) < 1 ? 1 : (((ns) + `ASRC_CLK_PERIOD_NS - 1) / \
  `ASRC_CLK_PERIOD_NS))
`define ASRC_FLOOR(ns) (((ns) / `ASRC_CLK_PERIOD_NS) < 1 ? 1 : \
  ((ns) / `ASRC_CLK_PERIOD_NS))
// Reads sized for the lower supply, so either supply range works
`define ASRC_RD_CYC   `ASRC_CEIL(`ASRC_LOW_SUPPLY_READ_MIN_NS)
`define ASRC_WR_CYC   `ASRC_CEIL(`ASRC_SELECT_TO_WR_END_MIN_NS)
`define ASRC_FLOAT_CYC `ASRC_CEIL(`ASRC_DESELECT_TO_FLOAT_MAX_NS)
`define ASRC_RECOVERY_CYC ((`ASRC_RECOVERY_MIN_MS * 1000000 + \
  `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)

`endif

// ==== core/asrc_pkg.sv ====
// Types for the static RAM host controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE,
    ASRC_READ,
    ASRC_WRITE,
    ASRC_FLOAT,
    ASRC_RETAIN,
    ASRC_RECOVER
  } asrc_state_t;

  typedef struct packed {
    logic        write;
    logic [18:0] addr;
    logic [7:0]  wdata;
  } asrc_req_t;

  typedef struct packed {
    logic chip_select_low_active_b;
    logic chip_select_high_active;
    logic output_enable_b;
    logic read_write_b;
  } asrc_ctl_t;
endpackage

// ==== verification/asrc_sram_model.sv ====
// Behavioural model of the 512K x 8 static RAM on the far side
`timescale 1ns/1ps

module asrc_sram_model
  import asrc_pkg::*;
(
  // Memory pins
  input  wire logic [18:0] i_addr,
  input  wire asrc_ctl_t   i_ctl,
  input  wire logic [7:0]  i_data,
  // Model drive
  output logic [7:0]       o_data,
  output logic             o_drive
);
  logic [7:0]  mem [int];
  logic [7:0]  last = 8'h00;
  logic [18:0] wa;
  logic [7:0]  wd;
  logic        sel;
  logic        wr;

  assign sel = ~i_ctl.chip_select_low_active_b &
               i_ctl.chip_select_high_active;
  assign wr = sel & ~i_ctl.read_write_b;
  // Output only in the read mode, never while strobe is low
  assign o_drive = sel & ~i_ctl.output_enable_b &
                   i_ctl.read_write_b;
  always @* if (wr) begin
    wa = i_addr;
    wd = i_data;
  end
  // Store what the bus held when the write ended
  always @(negedge wr) if (!$isunknown(wa)) mem[wa] = wd;
  always @(o_drive or i_addr) if (o_drive) begin
    last = mem.exists(i_addr) ? mem[i_addr] : 8'h00;
  end
  // No pull on the bus: released lines show the inverse
  assign o_data = o_drive ? last : ~last;
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the static RAM host controller
`timescale 1ns/1ps

module tb
  import asrc_pkg::*;
;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_req_valid = 1'b0;
  logic        i_retain = 1'b0;
  asrc_req_t   i_req = '0;
  logic        o_req_ready, o_rdata_valid, o_retained;
  logic        o_mem_data_oe, mem_drive;
  logic [7:0]  o_rdata, i_mem_data, o_mem_data, mem_q;
  logic [18:0] o_mem_addr;
  asrc_ctl_t   o_mem_ctl;
  int          err_total = 0;
  int          total_checks = 0;
  logic [7:0]  ref_mem [int];
  logic [18:0] adr [$];
  logic [31:0] r;

  always #25 i_clk_sys = ~i_clk_sys;
  assign i_mem_data = o_mem_data_oe ? o_mem_data : mem_q;

  asrc_host #(.RECOVERY_CYC(8)) asrc_host_inst (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid),
    .o_rdata(o_rdata), .i_retain(i_retain), .o_retained(o_retained),
    .o_mem_addr(o_mem_addr), .o_mem_ctl(o_mem_ctl),
    .i_mem_data(i_mem_data), .o_mem_data(o_mem_data),
    .o_mem_data_oe(o_mem_data_oe));
  asrc_sram_model asrc_sram_model_inst (
    .i_addr(o_mem_addr), .i_ctl(o_mem_ctl), .i_data(i_mem_data),
    .o_data(mem_q), .o_drive(mem_drive));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_d(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp_f(input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Bounded wait at falling edges for a flag to be high
  task automatic wait_hi(ref logic f);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    while (f !== 1'b1) begin
      n++;
      if (n > 40) begin
        err_total++;
        test_done();
      end
      @(negedge i_clk_sys);
    end
  endtask

  task automatic req(input logic w, input logic [18:0] a,
                     input logic [7:0] d);
    wait_hi(o_req_ready);
    i_req_valid = 1'b1;
    i_req = '{write: w, addr: a, wdata: d};
    @(negedge i_clk_sys);
    i_req_valid = 1'b0;
    if (w) begin
      ref_mem[a] = d;
    end else begin
      if (o_rdata_valid !== 1'b1) wait_hi(o_rdata_valid);
      cmp_d(ref_mem[a], o_rdata);
    end
  endtask

  // Host and memory must never drive the bus together
  always @(negedge i_clk_sys) if (i_rst_b) begin
    cmp_f(1'b0, o_mem_data_oe & mem_drive);
  end

  initial begin
    void'($urandom(32'h099d));
    repeat (8) @(negedge i_clk_sys);
    cmp_f(1'b1, o_mem_ctl.chip_select_low_active_b);
    i_rst_b = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      adr.push_back(r[18:0]);
      req(1'b1, r[18:0], r[26:19]);
    end
    adr.push_back(19'h7ffff);
    req(1'b1, 19'h7ffff, 8'ha5);
    foreach (adr[i]) req(1'b0, adr[i], 8'h00);
    req(1'b1, 19'h7ffff, 8'h3c);
    req(1'b0, 19'h7ffff, 8'h00);
    $display("read and write test done");
    wait_hi(o_req_ready);
    i_ce = 1'b0;
    i_req_valid = 1'b1;
    i_req = '{write: 1'b0, addr: adr[0], wdata: 8'h00};
    repeat (4) @(negedge i_clk_sys);
    cmp_f(1'b1, o_req_ready);
    i_req_valid = 1'b0;
    i_ce = 1'b1;
    $display("clock enable test done");
    wait_hi(o_req_ready);
    i_retain = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    cmp_f(1'b1, o_retained);
    cmp_f(1'b1, o_mem_ctl.chip_select_low_active_b |
                ~o_mem_ctl.chip_select_high_active);
    i_retain = 1'b0;
    repeat (8) begin
      @(negedge i_clk_sys);
      cmp_f(1'b0, o_req_ready);
    end
    foreach (adr[i]) req(1'b0, adr[i], 8'h00);
    $display("retention test done");
    test_done();
  end
endmodule
